// [pkg/tape_status_params.svh]
`ifndef TAPE_STATUS_PARAMS_SVH
`define TAPE_STATUS_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_IRQ_STAT  12'h008
`define OFS_IRQ_MASK  12'h00C
`define OFS_PHASE     12'h010

// ****************************************
// control fields
// ****************************************
`define CTRL_FUNC_LSB 0
`define CTRL_START    8

// ****************************************
// function codes
// ****************************************
`define FN_RDBACK     3'h2
`define FN_REWIND     3'h3
`define FN_BOOT       3'h4
`define FN_WRITE      3'h5
`define FN_RDFWD      3'h6
`define FN_SKIPW      3'h7

// ****************************************
// status word fields
// ****************************************
`define ST_INTERLOCK  0
`define ST_BUSY       1
`define ST_EOT_LP     2
`define ST_ZERO       3
`define ST_ONE        4
`define ST_LATE       5
`define ST_PARITY     6
`define ST_ABNORMAL   7
`define ST_REEL_END   8
`define ST_HASH       9
`define ST_INVALID    10
`define ST_MOD5_LSB   12
`define STATUS_RST    16'h0010

// ****************************************
// interrupt bits
// ****************************************
`define IRQ_DONE      0
`define IRQ_ERR       1
`define IRQ_MASK_RST  2'h0

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 100
`define LATE_LIMIT_NS 192000
`define LATE_CYC      (`LATE_LIMIT_NS / `CLK_PERIOD_NS)

`endif

// [pkg/tape_status_pkg.sv]
`default_nettype none
package tape_status_pkg;

  typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE, PH_FINISH} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [2:0]  func;
    logic [15:0] status;
    logic [2:0]  fcnt;
    logic        offer;
    logic [2:0]  offer_chars;
    logic        req;
    logic        later_word;
    logic [15:0] timer;
    logic        miss;
    logic        run;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } core_t;

endpackage
`default_nettype wire

// [hdl/tape_status.sv]
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "tape_status_params.svh"

module tape_status
  import tape_status_pkg::*;
#(
  parameter int LATE_CYCLES = `LATE_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // interrupt
  output var  logic        irq,
  // tape side
  input  wire logic        frame_strobe,
  input  wire logic        lat_par_err,
  input  wire logic        lrc_err,
  input  wire logic        block_end,
  input  wire logic        word_need,
  input  wire logic        eot_marker,
  input  wire logic        hash_err,
  input  wire logic        unit_interlock,
  input  wire logic        unit_busy,
  input  wire logic        unit_eot_lp,
  input  wire logic        func_invalid,
  output var  logic        run,
  output var  logic [2:0]  run_func,
  // processor channel
  output var  logic        word_offer,
  output var  logic [2:0]  word_chars,
  input  wire logic        word_take,
  output var  logic        word_req,
  input  wire logic        word_give
);

  // ****************************************
  // parameter check
  // ****************************************
  if (LATE_CYCLES < 1 || LATE_CYCLES > 65535) begin : g_bad_late
    $error("LATE_CYCLES out of range");
  end

  if (`ST_MOD5_LSB + 3 > 15) begin : g_bad_mod5
    $error("mod-5 field does not fit the status word");
  end

  if (`ST_INVALID >= `ST_MOD5_LSB) begin : g_bad_layout
    $error("status flags overlap the mod-5 field");
  end

  localparam logic [15:0] LATE_LAST = 16'(LATE_CYCLES - 1);

  core_t r;
  core_t n;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_IRQ_STAT) ||
             (a == `OFS_IRQ_MASK) || (a == `OFS_PHASE);
  endfunction

  function automatic logic [31:0] rd_mux(input core_t s, input logic [11:0] a);
    rd_mux = 32'h0000_0000;
    unique case (a)
      `OFS_CTRL:     rd_mux = {23'h00_0000, s.run, 5'h00, s.func};
      `OFS_STATUS:   rd_mux = {16'h0000, s.status};
      `OFS_IRQ_STAT: rd_mux = {30'h0000_0000, s.irq_stat};
      `OFS_IRQ_MASK: rd_mux = {30'h0000_0000, s.irq_mask};
      `OFS_PHASE:    rd_mux = {30'h0000_0000, s.phase};
      default:       rd_mux = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic is_write_fn(input logic [2:0] f);
    is_write_fn = (f == `FN_WRITE) || (f == `FN_SKIPW);
  endfunction

  // busy and eot_lp bits refreshed as read and write status is produced, busy gated by eot_lp
  function automatic logic [15:0] close_status(input logic [15:0] s, input logic busy,
                                               input logic eot_lp);
    close_status             = s;
    close_status[`ST_BUSY]   = busy & eot_lp;
    close_status[`ST_EOT_LP] = eot_lp;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic       access;
    logic       wr;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [2:0] fn;
    n      = r;
    access = psel & penable & r.pready;
    wr     = access & pwrite;
    ev     = 2'h0;
    clr    = 2'h0;
    fn     = pwdata[`CTRL_FUNC_LSB +: 3];

    // ****************************************
    // apb access
    // ****************************************
    // apb: one wait state, then answer
    n.pready  = psel & penable & ~r.pready;
    n.pslverr = psel & penable & ~r.pready & ~mapped(paddr);
    if (psel & penable & ~r.pready & ~pwrite) begin
      n.prdata = rd_mux(r, paddr);
    end
    if (wr && paddr == `OFS_IRQ_STAT) begin
      clr = pwdata[1:0];
    end
    if (wr && paddr == `OFS_IRQ_MASK) begin
      n.irq_mask = pwdata[1:0];
    end

    unique case (r.phase)
      // ****************************************
      // function start
      // ****************************************
      PH_IDLE: begin
        if (wr && paddr == `OFS_CTRL && pwdata[`CTRL_START]) begin
          n.func       = fn;
          n.status     = `STATUS_RST;
          n.fcnt       = 3'h0;
          n.offer      = 1'b0;
          n.req        = 1'b0;
          n.miss       = 1'b0;
          n.later_word = 1'b0;
          n.timer      = 16'h0000;
          if (unit_interlock || func_invalid || (unit_busy && !unit_eot_lp)) begin
            // unit conditions report alone, same for bootstrap as rewind
            n.status[`ST_INTERLOCK] = unit_interlock;
            n.status[`ST_INVALID]   = func_invalid & ~unit_interlock;
            n.status[`ST_BUSY]      = unit_busy & ~unit_interlock & ~func_invalid;
            ev[`IRQ_DONE]           = 1'b1;
          end else if (fn == `FN_REWIND) begin
            ev[`IRQ_DONE] = 1'b1;
          end else if (is_write_fn(fn)) begin
            n.run   = 1'b1;
            n.phase = PH_WRITE;
            n.req   = 1'b1;
          end else begin
            // bootstrap runs as a read forward
            n.run   = 1'b1;
            n.phase = PH_READ;
          end
        end
      end

      // ****************************************
      // read transfer
      // ****************************************
      PH_READ, PH_FINISH: begin
        // response deadline on an offered word
        if (r.offer) begin
          if (r.timer == LATE_LAST) begin
            n.miss = 1'b1;
          end else begin
            n.timer = r.timer + 16'h0001;
          end
        end
        if (r.offer && word_take) begin
          n.offer = 1'b0;
          // a miss belongs to the word in hand only
          n.miss  = 1'b0;
          if (r.miss) begin
            n.status[`ST_LATE] = 1'b1;
          end
          n.status[`ST_MOD5_LSB +: 3] = r.offer_chars;
        end
        if (r.phase == PH_READ && frame_strobe) begin
          if (lat_par_err) begin
            n.status[`ST_PARITY] = 1'b1;
          end
          // fifth frame completes a word
          if (r.fcnt == 3'h4) begin
            if (n.offer) begin
              n.miss = 1'b1;
            end
            n.offer       = 1'b1;
            n.offer_chars = 3'h0;
            n.timer       = 16'h0000;
            n.fcnt        = 3'h0;
          end else begin
            n.fcnt = r.fcnt + 3'h1;
          end
        end
        if (r.phase == PH_READ && block_end) begin
          if (lrc_err) begin
            n.status[`ST_PARITY] = 1'b1;
          end
          // leftover frames go out as a padded partial word
          if (r.fcnt != 3'h0) begin
            if (n.offer) begin
              n.miss = 1'b1;
            end
            n.offer                = 1'b1;
            n.offer_chars          = r.fcnt;
            n.timer                = 16'h0000;
            n.status[`ST_ABNORMAL] = 1'b1;
          end
          n.phase = PH_FINISH;
        end
        // eot_marker deliberately ignored while reading
        // status waits until the last word is taken or missed
        if (r.phase == PH_FINISH && (!r.offer || r.miss)) begin
          n.offer                = 1'b0;
          n.run                  = 1'b0;
          n.phase                = PH_IDLE;
          n.status               = close_status(n.status, unit_busy, unit_eot_lp);
          ev[`IRQ_DONE]          = 1'b1;
          ev[`IRQ_ERR]           = r.status[`ST_LATE] | r.status[`ST_PARITY];
        end
      end

      // ****************************************
      // write transfer
      // ****************************************
      PH_WRITE: begin
        // deadline applies from the second word on
        if (r.req && r.later_word) begin
          if (r.timer == LATE_LAST) begin
            n.miss = 1'b1;
          end else begin
            n.timer = r.timer + 16'h0001;
          end
        end
        if (r.req && word_give) begin
          n.req        = 1'b0;
          n.later_word = 1'b1;
          n.miss       = 1'b0;
          if (r.miss && r.later_word) begin
            n.status[`ST_LATE] = 1'b1;
          end
        end
        if (word_need) begin
          // a new need while a later word is still owed counts as missed
          if (n.req && r.later_word) begin
            n.miss = 1'b1;
          end
          n.req   = 1'b1;
          n.timer = 16'h0000;
        end
        // frames seen by the read-back check
        if (frame_strobe && lat_par_err) begin
          n.status[`ST_PARITY] = 1'b1;
        end
        if (block_end && lrc_err) begin
          n.status[`ST_PARITY] = 1'b1;
        end
        if (eot_marker) begin
          n.status[`ST_REEL_END] = 1'b1;
        end
        if (hash_err) begin
          n.status[`ST_HASH] = 1'b1;
        end
        if (block_end) begin
          n.req                = 1'b0;
          n.run                = 1'b0;
          n.phase              = PH_IDLE;
          n.status             = close_status(n.status, unit_busy, unit_eot_lp);
          ev[`IRQ_DONE]        = 1'b1;
          ev[`IRQ_ERR]         = n.status[`ST_LATE] | n.status[`ST_PARITY] |
                                 n.status[`ST_HASH];
        end
      end
    endcase

    // ****************************************
    // fixed status bits
    // ****************************************
    n.status[`ST_ZERO] = 1'b0;
    n.status[`ST_ONE]  = 1'b1;
    n.status[11]       = 1'b0;
    n.status[15]       = 1'b0;

    // ****************************************
    // interrupt
    // ****************************************
    // set wins over write-one clear
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{
        phase:       PH_IDLE,
        func:        3'h0,
        status:      `STATUS_RST,
        fcnt:        3'h0,
        offer:       1'b0,
        offer_chars: 3'h0,
        req:         1'b0,
        later_word:  1'b0,
        timer:       16'h0000,
        miss:        1'b0,
        run:         1'b0,
        irq_stat:    2'h0,
        irq_mask:    `IRQ_MASK_RST,
        irq:         1'b0,
        pready:      1'b0,
        pslverr:     1'b0,
        prdata:      32'h0000_0000
      };
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign irq        = r.irq;
  assign run        = r.run;
  assign run_func   = r.func;
  assign word_offer = r.offer;
  assign word_chars = r.offer_chars;
  assign word_req   = r.req;

endmodule // tape_status
`default_nettype wire

// [verification/tape_status_checker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tape_status_params.svh"

module tape_status_checker #(
  parameter int LATE_CYCLES = 8
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // tape and channel
  input wire logic        block_end,
  input wire logic        run,
  input wire logic [2:0]  run_func,
  input wire logic        word_offer,
  input wire logic [2:0]  word_chars,
  input wire logic        word_take,
  input wire logic        word_req,
  input wire logic        word_give
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_st = pready && !pwrite && paddr == `OFS_STATUS && !pslverr;
  wire logic wr_fn = run_func == `FN_WRITE || run_func == `FN_SKIPW;

  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("apb answer timing wrong");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_one; rd_st |-> prdata[`ST_ONE] && !prdata[`ST_ZERO]; endproperty
  a_one: assert property (p_one) else $error("status fixed bits wrong");
  property p_fwd; rd_st && !run && run_func == `FN_RDFWD |-> !prdata[`ST_REEL_END]; endproperty
  a_fwd: assert property (p_fwd) else $error("reel end flag on read forward");
  property p_chars; word_offer |-> word_chars < 3'h5; endproperty
  a_chars: assert property (p_chars) else $error("partial count out of range");
  property p_take; word_offer && word_take |=> !word_offer; endproperty
  a_take: assert property (p_take) else $error("offer kept after take");
  property p_give; word_req && word_give |=> !word_req; endproperty
  a_give: assert property (p_give) else $error("request kept after give");
  property p_wend; run && wr_fn && block_end |=> !run; endproperty
  a_wend: assert property (p_wend) else $error("write status not produced");
  property p_func; run && $past(run) |-> $stable(run_func); endproperty
  a_func: assert property (p_func) else $error("function changed in run");
endmodule // tape_status_checker

bind tape_status tape_status_checker #(.LATE_CYCLES(LATE_CYCLES)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .block_end, .run,
  .run_func, .word_offer, .word_chars, .word_take, .word_req, .word_give);
`default_nettype wire

// [verification/channel_model.sv]
`timescale 1ns/10ps
`default_nettype none

module channel_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // channel
  input  wire logic        word_offer,
  input  wire logic        word_req,
  input  wire logic [15:0] dly,
  output var  logic        word_take,
  output var  logic        word_give
);
  logic [15:0] cnt;

  // answer each offer or request once, dly+1 cycles after it appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 16'h0000;
      word_take <= 1'b0;
      word_give <= 1'b0;
    end else begin
      word_take <= word_offer && cnt == dly;
      word_give <= word_req && cnt == dly;
      if (!(word_offer || word_req)) cnt <= 16'h0000;
      else if (cnt != 16'hffff) cnt <= cnt + 16'h0001;
    end
  end
endmodule // channel_model
`default_nettype wire

// [verification/tape_transfer_status_logic_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tape_status_params.svh"

module tape_transfer_status_logic_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic        frame_strobe = 0, lat_par_err = 0, lrc_err = 0, block_end = 0;
  logic        word_need = 0, eot_marker = 0, hash_err = 0, unit_interlock = 0;
  logic        unit_busy = 0, unit_eot_lp = 0, func_invalid = 0;
  logic [15:0] dly = 2;
  wire logic   pready, pslverr, irq, run, word_offer, word_req, word_take, word_give;
  wire logic [31:0] prdata;
  wire logic [2:0]  run_func, word_chars;
  int          fail_count = 0, n_compared = 0, cyc = 0;
  logic [31:0] boot_exp [3] = '{32'h0000_0011, 32'h0000_0012, 32'h0000_0410};

  tape_status #(.LATE_CYCLES(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .frame_strobe, .lat_par_err, .lrc_err,
    .block_end, .word_need, .eot_marker, .hash_err, .unit_interlock, .unit_busy,
    .unit_eot_lp, .func_invalid, .run, .run_func, .word_offer, .word_chars, .word_take,
    .word_req, .word_give);
  channel_model u_chan (.pclk, .presetn, .word_offer, .word_req, .dly, .word_take,
    .word_give);

  initial begin
    forever #50 pclk = ~pclk;
  end

  // ****
  // tasks
  // ****
  task close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task go(input logic [2:0] f);
    apb(1, `OFS_CTRL, 32'h0000_0100 | f);
  endtask

  task fr(input int n, input logic p);
    repeat (n) begin
      @(posedge pclk) begin frame_strobe <= 1; lat_par_err <= p; end
      @(posedge pclk) begin frame_strobe <= 0; lat_par_err <= 0; end
    end
    repeat (20) @(posedge pclk);
  endtask

  task ev(input logic [4:0] v);
    @(posedge pclk) {word_need, block_end, lrc_err, eot_marker, hash_err} <= v;
    @(posedge pclk) {word_need, block_end, lrc_err, eot_marker, hash_err} <= 5'h00;
  endtask

  task fin(input logic [31:0] e, input logic [31:0] msk, input string m);
    repeat (2) @(posedge pclk);
    while (run) @(posedge pclk);
    apb(0, `OFS_STATUS, 0);
    chk(rd & msk, e, m);
    $display("end %s", m);
  endtask

  // ****
  // tests
  // ****
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `OFS_STATUS, 0);
    chk(rd, 32'h0000_0010, "reset status");
    go(`FN_RDFWD);
    fr(5, 1);
    ev(5'h02);
    fr(3, 0);
    ev(5'h08);
    fin(32'h0000_30d0, 32'h0000_ffff, "read fwd");
    chk(irq, 32'h0000_0000, "irq masked");
    apb(1, `OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0000_0001, "irq raised");
    apb(1, `OFS_IRQ_STAT, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0000_0000, "irq cleared");
    $display("end irq");
    dly <= 12;
    go(`FN_RDBACK);
    fr(5, 0);
    fr(5, 0);
    ev(5'h08);
    fin(32'h0000_0030, 32'h0000_ffff, "read back late");
    go(`FN_WRITE);
    repeat (20) @(posedge pclk);
    ev(5'h10);
    fr(5, 0);
    ev(5'h03);
    ev(5'h0c);
    fin(32'h0000_0370, 32'h0000_0fff, "write");
    dly <= 2;
    go(`FN_SKIPW);
    fr(5, 0);
    ev(5'h02);
    ev(5'h08);
    fin(32'h0000_0110, 32'h0000_0fff, "skip write");
    for (int i = 0; i < 3; i++) begin
      {unit_interlock, unit_busy, func_invalid} <= 3'h4 >> i;
      go(`FN_BOOT);
      fin(boot_exp[i], 32'h0000_ffff, "boot unit");
    end
    {unit_interlock, unit_busy, unit_eot_lp, func_invalid} <= 4'h6;
    go(`FN_BOOT);
    fr(5, 0);
    ev(5'h0a);
    fin(32'h0000_0016, 32'h0000_ffff, "boot read");
    {unit_busy, unit_eot_lp} <= 2'h0;
    go(`FN_REWIND);
    fin(32'h0000_0010, 32'h0000_ffff, "rewind");
    apb(0, 12'h020, 0);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
    $display("end unmapped");
    close_out();
  end
endmodule // tape_transfer_status_logic_tb
`default_nettype wire
